// *** core/frl_ctrl.sv ***
/*
  Flash read and hard lock controller with an AHB-Lite register slave.
  Assumes a byte-wide flash array that answers with a done pulse, and a
  tool-mode chip erase pulse from the tool interface logic.
*/
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module frl_ctrl (
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic tool_chip_erase,
  output logic fl_req,
  output logic fl_write,
  output logic fl_erase,
  output logic [15:0] fl_addr,
  output logic [7:0] fl_wdata,
  input wire logic [7:0] fl_rdata,
  input wire logic fl_done,
  input wire logic fl_fail,
  output logic hard_lock,
  output logic irq
);
  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  logic ap_wr_q, ap_wr_d, ap_rd_q, ap_rd_d;
  logic [7:0] ap_addr_q, ap_addr_d;
  logic start;
  logic [7:0] wb;
  assign start = hsel & hready & htrans[1];
  assign wb = hwdata[7:0];
  always_comb begin
    ap_wr_d = start & hwrite;
    ap_rd_d = start & ~hwrite;
    ap_addr_d = start ? haddr : ap_addr_q;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      ap_wr_q <= 1'b0;
      ap_rd_q <= 1'b0;
      ap_addr_q <= 8'h00;
    end else begin
      ap_wr_q <= ap_wr_d;
      ap_rd_q <= ap_rd_d;
      ap_addr_q <= ap_addr_d;
    end
  end
  logic wr_cmd, wr_key, wr_padr, wr_pdat, wr_stat, rd_pdat;
  assign wr_cmd = ap_wr_q & (ap_addr_q == frl_pkg::ADDR_CMD);
  assign wr_key = ap_wr_q & (ap_addr_q == frl_pkg::ADDR_KEY);
  assign wr_padr = ap_wr_q & (ap_addr_q == frl_pkg::ADDR_PADR);
  assign wr_pdat = ap_wr_q & (ap_addr_q == frl_pkg::ADDR_PDAT);
  assign wr_stat = ap_wr_q & (ap_addr_q == frl_pkg::ADDR_STAT);
  assign rd_pdat = ap_rd_q & (ap_addr_q == frl_pkg::ADDR_PDAT);
  // ----------------------------------------------------------------
  // Registers and sequencer
  // ----------------------------------------------------------------
  logic [7:0] cmd_q, cmd_d, key_q, key_d, sech_q, sech_d, secl_q, secl_d;
  logic [15:0] padr_q, padr_d;
  logic [7:0] rbyte_q, rbyte_d;
  logic [2:0] ien_q, ien_d;
  logic lock_q, lock_d, armed_q, armed_d, busy_d, rdv_q, rdv_d;
  frl_pkg::frl_state_t st_q, st_d;
  logic keyed, ev_read, ev_done, ev_ref;
  logic req_d, fwr_d, fer_d;
  logic [15:0] fadr_d;
  logic [7:0] fwd_d;
  logic req_q, fwr_q, fer_q;
  logic [15:0] fadr_q;
  logic [7:0] fwd_q;
  assign keyed = (key_q == frl_pkg::KEY_VALUE);
  always_comb begin
    cmd_d = cmd_q;
    key_d = wr_key ? wb : key_q;
    sech_d = (ap_wr_q && ap_addr_q == frl_pkg::ADDR_SECH) ? wb : sech_q;
    secl_d = (ap_wr_q && ap_addr_q == frl_pkg::ADDR_SECL) ? wb : secl_q;
    padr_d = wr_padr ? hwdata[15:0] : padr_q;
    ien_d = (ap_wr_q && ap_addr_q == frl_pkg::ADDR_IEN) ? hwdata[2:0] : ien_q;
    rbyte_d = rbyte_q;
    lock_d = lock_q;
    armed_d = armed_q;
    st_d = st_q;
    req_d = 1'b0;
    fwr_d = 1'b0;
    fer_d = 1'b0;
    fadr_d = fadr_q;
    fwd_d = fwd_q;
    ev_read = 1'b0;
    ev_done = 1'b0;
    ev_ref = 1'b0;
    // Writing zero releases the command modes, never the lock
    if (wr_cmd && wb == 8'h00) begin
      cmd_d = 8'h00;
      armed_d = 1'b0;
    end else if (wr_cmd && keyed) begin
      cmd_d = {wb[7:4], cmd_q[frl_pkg::FAIL_BIT], wb[2:0]};
      if (wb[7:4] == frl_pkg::LOCK_NIB) begin
        lock_d = 1'b1;
      end else if (lock_q && (wb == frl_pkg::CMD_ERASE ||
                              wb == frl_pkg::CMD_PROG)) begin
        ev_ref = 1'b1;
      end else if (wb == frl_pkg::CMD_ERASE && st_q == frl_pkg::FRL_IDLE) begin
        st_d = frl_pkg::FRL_ERASE;
        req_d = 1'b1;
        fer_d = 1'b1;
        fadr_d = {sech_q, secl_q};
        cmd_d[frl_pkg::FAIL_BIT] = 1'b0;
      end else if (wb == frl_pkg::CMD_PROG) begin
        armed_d = 1'b1;
      end
    end
    if (!keyed) begin
      armed_d = 1'b0;
    end
    // Store through the data window after arming programs one byte
    if (wr_pdat && st_q == frl_pkg::FRL_IDLE) begin
      if (armed_q && keyed && !lock_q &&
          padr_q[15:7] == {sech_q, secl_q[7]}) begin
        st_d = frl_pkg::FRL_PROG;
        req_d = 1'b1;
        fwr_d = 1'b1;
        fadr_d = padr_q;
        fwd_d = wb;
        armed_d = 1'b0;
      end else if (armed_q) begin
        ev_ref = 1'b1;
        armed_d = 1'b0;
      end
    end
    // Load from program memory, no key checked
    if (wr_padr && st_q == frl_pkg::FRL_IDLE) begin
      st_d = frl_pkg::FRL_READ;
      req_d = 1'b1;
      fadr_d = hwdata[15:0];
    end
    if (fl_done && st_q != frl_pkg::FRL_IDLE) begin
      st_d = frl_pkg::FRL_IDLE;
      ev_done = (st_q != frl_pkg::FRL_READ);
      if (st_q == frl_pkg::FRL_READ) begin
        rbyte_d = fl_rdata;
        ev_read = 1'b1;
      end
      if (st_q == frl_pkg::FRL_ERASE) begin
        cmd_d[frl_pkg::FAIL_BIT] = fl_fail;
      end
    end
    if (tool_chip_erase) begin
      lock_d = 1'b0;
    end
  end
  assign busy_d = (st_d != frl_pkg::FRL_IDLE);
  assign rdv_d = ev_read | (rdv_q & ~rd_pdat & ~wr_padr);
  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_q <= 8'h00;
      key_q <= 8'h00;
      sech_q <= 8'h00;
      secl_q <= 8'h00;
      padr_q <= 16'h0000;
      rbyte_q <= 8'h00;
      ien_q <= 3'h0;
      lock_q <= 1'b0;
      armed_q <= 1'b0;
      rdv_q <= 1'b0;
      st_q <= frl_pkg::FRL_IDLE;
      req_q <= 1'b0;
      fwr_q <= 1'b0;
      fer_q <= 1'b0;
      fadr_q <= 16'h0000;
      fwd_q <= 8'h00;
    end else begin
      cmd_q <= cmd_d;
      key_q <= key_d;
      sech_q <= sech_d;
      secl_q <= secl_d;
      padr_q <= padr_d;
      rbyte_q <= rbyte_d;
      ien_q <= ien_d;
      lock_q <= lock_d;
      armed_q <= armed_d;
      rdv_q <= rdv_d;
      st_q <= st_d;
      req_q <= req_d;
      fwr_q <= fwr_d;
      fer_q <= fer_d;
      fadr_q <= fadr_d;
      fwd_q <= fwd_d;
    end
  end
  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  logic [2:0] stat;
  frl_sticky u_sticky (
    .clk(clk),
    .srst(srst),
    .event_in({ev_ref, ev_done, ev_read}),
    .clear_in(wr_stat ? hwdata[2:0] : 3'h0),
    .mask_in(ien_q),
    .status(stat),
    .irq(irq)
  );
  // ----------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------
  logic [31:0] rd_d, rd_q;
  always_comb begin
    rd_d = 32'h0000_0000;
    if (start && !hwrite) begin
      case (haddr)
        frl_pkg::ADDR_CMD: rd_d = {24'h0, cmd_d};
        frl_pkg::ADDR_KEY: rd_d = {24'h0, key_d};
        frl_pkg::ADDR_SECH: rd_d = {24'h0, sech_d};
        frl_pkg::ADDR_SECL: rd_d = {24'h0, secl_d};
        frl_pkg::ADDR_PADR: rd_d = {16'h0, padr_d};
        frl_pkg::ADDR_PDAT: rd_d = {22'h0, busy_d, rdv_d, rbyte_d};
        frl_pkg::ADDR_STAT: rd_d = {28'h0, lock_d, stat};
        frl_pkg::ADDR_IEN: rd_d = {29'h0, ien_d};
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_q <= 32'h0000_0000;
    end else begin
      rd_q <= rd_d;
    end
  end
  assign hrdata = rd_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign fl_req = req_q;
  assign fl_write = fwr_q;
  assign fl_erase = fer_q;
  assign fl_addr = fadr_q;
  assign fl_wdata = fwd_q;
  assign hard_lock = lock_q;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_lock_set;
    @(posedge clk) disable iff (srst)
      (wr_cmd && keyed && wb[7:4] == frl_pkg::LOCK_NIB && !tool_chip_erase)
      |=> hard_lock;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock not set");
  property p_no_write_locked;
    @(posedge clk) disable iff (srst)
      $past(lock_q) && lock_q |-> !(fl_req && (fl_write || fl_erase));
  endproperty
  a_no_write_locked: assert property (p_no_write_locked)
    else $error("flash change while locked");
  property p_lock_hold;
    @(posedge clk) disable iff (srst)
      hard_lock && !tool_chip_erase |=> hard_lock;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock lost");
  property p_lock_clear;
    @(posedge clk) disable iff (srst)
      tool_chip_erase |=> !hard_lock;
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("lock kept");
  property p_unkeyed;
    @(posedge clk) disable iff (srst)
      wr_cmd && !keyed && wb != 8'h00 |=> $stable(cmd_q) && !fer_q;
  endproperty
  a_unkeyed: assert property (p_unkeyed) else $error("unkeyed cmd");
  property p_read;
    @(posedge clk) disable iff (srst)
      wr_padr && st_q == frl_pkg::FRL_IDLE |=> fl_req && !fl_write &&
        !fl_erase && fl_addr == $past(hwdata[15:0]);
  endproperty
  a_read: assert property (p_read) else $error("read not issued");
  property p_erase;
    @(posedge clk) disable iff (srst)
      wr_cmd && keyed && !lock_q && wb == frl_pkg::CMD_ERASE &&
      st_q == frl_pkg::FRL_IDLE |=> fl_erase && fl_addr == {sech_q, secl_q};
  endproperty
  a_erase: assert property (p_erase) else $error("erase not issued");
  property p_fail;
    @(posedge clk) disable iff (srst)
      fl_done && st_q == frl_pkg::FRL_ERASE |=>
        cmd_q[frl_pkg::FAIL_BIT] == $past(fl_fail);
  endproperty
  a_fail: assert property (p_fail) else $error("fail bit wrong");
  property p_prog;
    @(posedge clk) disable iff (srst)
      fwr_q |-> fl_req && $past(armed_q);
  endproperty
  a_prog: assert property (p_prog) else $error("unarmed program");
  c_lock: cover property (@(posedge clk) disable iff (srst) $rose(lock_q));
  c_read: cover property (@(posedge clk) disable iff (srst) ev_read);
  c_ref: cover property (@(posedge clk) disable iff (srst) ev_ref);
endmodule // frl_ctrl

// *** core/frl_pkg.sv ***
/*
  Constants, register map and command codes of the flash read and
  hard lock block.
  Assumes a 32-bit AHB-Lite slave port and a byte-wide flash array port.
*/
// Contract
// - A program-memory load returns one flash byte; no key needed.
// - Writing 0110 in command bits 7..4 while keyed sets hard lock.
// - While hard lock holds, every user write and erase is refused.
// - Only a tool-mode chip erase clears hard lock; the code also clears it on srst.
// - Writing A1 while keyed starts a sector erase of the sector address.
// - Writing 51 while keyed arms one byte program by the next store.
// - Command bit 3 reports a failed sector erase.
package frl_pkg;
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_KEY = 8'h04;
  localparam logic [7:0] ADDR_SECH = 8'h08;
  localparam logic [7:0] ADDR_SECL = 8'h0C;
  localparam logic [7:0] ADDR_PADR = 8'h10;
  localparam logic [7:0] ADDR_PDAT = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [7:0] ADDR_IEN = 8'h1C;
  localparam logic [7:0] KEY_VALUE = 8'hA5;
  localparam logic [3:0] LOCK_NIB = 4'h6;
  localparam logic [7:0] CMD_LOCK = 8'h61;
  localparam logic [7:0] CMD_ERASE = 8'hA1;
  localparam logic [7:0] CMD_PROG = 8'h51;
  localparam int FAIL_BIT = 3;
  localparam int EV_READ = 0;
  localparam int EV_DONE = 1;
  localparam int EV_REFUSED = 2;
  localparam int NUM_EV = 3;
  typedef enum logic [1:0] {
    FRL_IDLE = 2'b00,
    FRL_READ = 2'b01,
    FRL_ERASE = 2'b10,
    FRL_PROG = 2'b11
  } frl_state_t;
endpackage

// *** core/frl_sticky.sv ***
/*
  Sticky event bits, write-one-to-clear, masked onto one interrupt.
  Assumes events and clears come from the same clock.
*/
`timescale 1ns/100ps
module frl_sticky (
  input wire logic clk,
  input wire logic srst,
  input wire logic [frl_pkg::NUM_EV-1:0] event_in,
  input wire logic [frl_pkg::NUM_EV-1:0] clear_in,
  input wire logic [frl_pkg::NUM_EV-1:0] mask_in,
  output logic [frl_pkg::NUM_EV-1:0] status,
  output logic irq
);
  logic [frl_pkg::NUM_EV-1:0] stat_q, stat_d;
  logic irq_q, irq_d;
  genvar i;
  for (i = 0; i < frl_pkg::NUM_EV; i++) begin : g_bit
    // Set wins over a clear in the same cycle
    always_comb begin
      stat_d[i] = event_in[i] | (stat_q[i] & ~clear_in[i]);
    end
  end
  always_comb begin
    irq_d = |(stat_d & mask_in);
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q <= irq_d;
    end
  end
  assign status = stat_q;
  assign irq = irq_q;
endmodule // frl_sticky

// *** tb/frl_flash_model.sv ***
/*
  Behavioural byte-wide flash array seen by the controller.
  Assumes one request at a time; the bench sets delay and erase failure.
*/
`timescale 1ns/100ps
module frl_flash_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic fl_req,
  input wire logic fl_write,
  input wire logic fl_erase,
  input wire logic [15:0] fl_addr,
  input wire logic [7:0] fl_wdata,
  input wire logic [7:0] delay,
  input wire logic fail_next,
  output logic [7:0] fl_rdata,
  output logic fl_done,
  output logic fl_fail,
  output logic [15:0] req_cnt,
  output logic last_write,
  output logic last_erase,
  output logic [15:0] last_addr,
  output logic [7:0] last_wdata
);
  logic busy;
  logic [7:0] wait_c;
  // ----------------------------------------
  // Operation timing
  // ----------------------------------------
  always @(posedge clk) begin
    fl_done <= 1'b0;
    // Released lines never hold the last value
    fl_rdata <= ~fl_rdata;
    fl_fail <= ~fl_fail;
    if (srst) begin
      busy <= 1'b0;
      req_cnt <= 16'h0000;
      fl_rdata <= 8'h00;
      fl_fail <= 1'b0;
    end else if (fl_req && !busy) begin
      busy <= 1'b1;
      wait_c <= delay;
      req_cnt <= req_cnt + 16'h0001;
      last_write <= fl_write;
      last_erase <= fl_erase;
      last_addr <= fl_addr;
      last_wdata <= fl_wdata;
    end else if (busy && wait_c == 8'h00) begin
      busy <= 1'b0;
      fl_done <= 1'b1;
      fl_rdata <= last_addr[7:0] ^ last_addr[15:8] ^ 8'h5A;
      fl_fail <= fail_next & last_erase;
    end else if (busy) begin
      wait_c <= wait_c - 8'h01;
    end
  end
endmodule // frl_flash_model

// *** tb/tb_flash_read_and_hard_lock.sv ***
/*
  Self-checking bench: AHB-Lite master tasks driving the controller.
  Assumes the flash model in frl_flash_model and zero-wait slave timing.
*/
`timescale 1ns/100ps
module tb_flash_read_and_hard_lock;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic tool_chip_erase = 1'b0;
  logic fail_next = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic [7:0] fl_delay = 8'h00;
  logic hready, hreadyout, hresp, fl_req, fl_write, fl_erase, fl_done;
  logic fl_fail, hard_lock, irq, last_write, last_erase;
  logic [15:0] fl_addr, last_addr, req_cnt, n, a;
  logic [7:0] fl_wdata, fl_rdata, last_wdata;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;

  always #25 clk = ~clk;
  assign hready = hreadyout;

  frl_ctrl dut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tool_chip_erase(tool_chip_erase), .fl_req(fl_req),
    .fl_write(fl_write), .fl_erase(fl_erase), .fl_addr(fl_addr),
    .fl_wdata(fl_wdata), .fl_rdata(fl_rdata), .fl_done(fl_done),
    .fl_fail(fl_fail), .hard_lock(hard_lock), .irq(irq));

  frl_flash_model flash (.clk(clk), .srst(srst), .fl_req(fl_req),
    .fl_write(fl_write), .fl_erase(fl_erase), .fl_addr(fl_addr),
    .fl_wdata(fl_wdata), .delay(fl_delay), .fail_next(fail_next),
    .fl_rdata(fl_rdata), .fl_done(fl_done), .fl_fail(fl_fail),
    .req_cnt(req_cnt), .last_write(last_write), .last_erase(last_erase),
    .last_addr(last_addr), .last_wdata(last_wdata));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic poll(input logic [7:0] ad, input int b);
    int k;
    k = 0;
    rd = 32'h0;
    while (rd[b] !== 1'b1 && k < 40) begin
      ahb(1'b0, ad, 32'h0);
      k++;
    end
    if (rd[b] !== 1'b1) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, rd, 32'h1 << b);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk({31'h0, hard_lock}, 32'h0);
    ahb(1'b1, 8'h20, 32'hFF);
    ahb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, frl_pkg::ADDR_STAT, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    ahb(1'b1, frl_pkg::ADDR_IEN, 32'h7);
    // Keyless reads, prompt and slow flash
    for (int i = 0; i < 2; i++) begin
      a = (i == 0) ? 16'h0300 : 16'h03FF;
      fl_delay <= (i == 0) ? 8'h00 : 8'h05;
      ahb(1'b1, frl_pkg::ADDR_PADR, {16'h0, a});
      poll(frl_pkg::ADDR_PDAT, 8);
      chk(rd & 32'h3FF, {22'h1, a[7:0] ^ a[15:8] ^ 8'h5A});
      chk({31'h0, irq}, 32'h1);
      ahb(1'b1, frl_pkg::ADDR_STAT, 32'h1);
      ahb(1'b0, frl_pkg::ADDR_STAT, 32'h0);
      chk({rd[2:0], irq}, 4'h0);
    end
    n = req_cnt;
    ahb(1'b1, frl_pkg::ADDR_CMD, 32'hA1);
    ahb(1'b0, frl_pkg::ADDR_CMD, 32'h0);
    chk({rd[7:0], req_cnt}, {8'h00, n});
    // Keyed erase that fails, then abandon
    fail_next <= 1'b1;
    ahb(1'b1, frl_pkg::ADDR_KEY, 32'hA5);
    ahb(1'b1, frl_pkg::ADDR_SECH, 32'h10);
    ahb(1'b1, frl_pkg::ADDR_SECL, 32'h00);
    ahb(1'b1, frl_pkg::ADDR_CMD, 32'hA1);
    poll(frl_pkg::ADDR_STAT, 1);
    chk({last_erase, last_addr}, 17'h11000);
    ahb(1'b0, frl_pkg::ADDR_CMD, 32'h0);
    chk({31'h0, rd[3]}, 32'h1);
    fail_next <= 1'b0;
    ahb(1'b1, frl_pkg::ADDR_KEY, 32'h0);
    ahb(1'b1, frl_pkg::ADDR_CMD, 32'h0);
    ahb(1'b0, frl_pkg::ADDR_CMD, 32'h0);
    chk(rd & 32'hFF, 32'h0);
    ahb(1'b1, frl_pkg::ADDR_STAT, 32'h7);
    // Program one byte in sector 1780
    ahb(1'b1, frl_pkg::ADDR_KEY, 32'hA5);
    ahb(1'b1, frl_pkg::ADDR_SECH, 32'h17);
    ahb(1'b1, frl_pkg::ADDR_SECL, 32'h80);
    ahb(1'b1, frl_pkg::ADDR_CMD, 32'h51);
    ahb(1'b1, frl_pkg::ADDR_PADR, 32'h1784);
    // Address write starts a load; store only once it is done
    poll(frl_pkg::ADDR_PDAT, 8);
    ahb(1'b1, frl_pkg::ADDR_PDAT, 32'h78);
    poll(frl_pkg::ADDR_STAT, 1);
    chk({last_write, last_addr, last_wdata}, 25'h117_8478);
    ahb(1'b1, frl_pkg::ADDR_KEY, 32'h0);
    ahb(1'b1, frl_pkg::ADDR_STAT, 32'h7);
    // Hard lock sequence with one idle slot
    ahb(1'b1, frl_pkg::ADDR_KEY, 32'hA5);
    ahb(1'b1, frl_pkg::ADDR_CMD, 32'h61);
    @(posedge clk);
    ahb(1'b1, frl_pkg::ADDR_KEY, 32'h0);
    ahb(1'b0, frl_pkg::ADDR_STAT, 32'h0);
    chk({rd[3], hard_lock}, 2'h3);
    // Locked: erase and program refused, reads still served
    n = req_cnt;
    ahb(1'b1, frl_pkg::ADDR_KEY, 32'hA5);
    ahb(1'b1, frl_pkg::ADDR_CMD, 32'hA1);
    poll(frl_pkg::ADDR_STAT, 2);
    chk({rd[2], irq, req_cnt}, {2'h3, n});
    ahb(1'b1, frl_pkg::ADDR_STAT, 32'h4);
    ahb(1'b1, frl_pkg::ADDR_CMD, 32'h51);
    ahb(1'b1, frl_pkg::ADDR_PDAT, 32'h33);
    poll(frl_pkg::ADDR_STAT, 2);
    chk({rd[2], req_cnt}, {1'b1, n});
    ahb(1'b1, frl_pkg::ADDR_PADR, 32'h0342);
    poll(frl_pkg::ADDR_PDAT, 8);
    chk(rd & 32'hFF, 32'h1B);
    ahb(1'b1, frl_pkg::ADDR_CMD, 32'h0);
    ahb(1'b1, frl_pkg::ADDR_KEY, 32'h0);
    chk({31'h0, hard_lock}, 32'h1);
    tool_chip_erase <= 1'b1;
    @(posedge clk);
    tool_chip_erase <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, hard_lock}, 32'h0);
    wrap_up();
  end
endmodule // tb_flash_read_and_hard_lock
